// ### rtl/usdp_top.sv
// Shadow data port of a UART: aliased data words, FIFOs and line status over AXI4-Lite.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Sixteen consecutive aliased words all reach the same receive and transmit data.
// - A shadow read returns the received byte from the UART or infrared input.
// - Received data counts as valid only while the data-ready flag is set.
// - Without FIFOs a new character overwrites an unread one and flags overrun.
// - With FIFOs a shadow read returns the head of the receive FIFO.
// - A character arriving at a full receive FIFO that is not read in that cycle is dropped and flags overrun.
// - A shadow write sends a character on the UART or infrared output.
// - Without FIFOs one character write clears the holding-empty flag.
// - Without FIFOs further writes before the flag sets replace the pending character.
// - With FIFOs, writes are accepted up to the FIFO depth before it is full.
// - A write to a full transmit FIFO that is not popped in that cycle is dropped, contents unchanged.
module usdp_top #(
    parameter int DEPTH = usdp_pkg::FIFO_DEPTH
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic [31:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [31:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire usdp_pkg::usdp_char_s UART_RX,
    input wire usdp_pkg::usdp_char_s IR_RX,
    input wire logic TX_READY,
    output logic [7:0] TX_DATA,
    output logic UART_TX_VALID,
    output logic IR_TX_VALID
);
    import usdp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // All state of the port outside the two FIFOs.
    typedef struct packed {
        logic aw_have;
        logic [31:0] awaddr;
        logic w_have;
        logic [7:0] wdata;
        logic wbyte;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic fifo_en;
        logic ir_mode;
        logic overrun;
        logic [7:0] rx_hold;
        logic rx_valid;
        logic [7:0] tx_hold;
        logic tx_holding_empty;
    } usdp_state_s;

    usdp_state_s q;
    usdp_state_s d;

    usdp_char_s rx_in;
    logic rx_push;
    logic rx_pop;
    logic rxf_ready;
    logic rxf_valid;
    logic [7:0] rxf_data;
    logic rxf_full;
    logic tx_push;
    logic tx_pop;
    logic txf_valid;
    logic [7:0] txf_data;
    logic flush;
    logic data_ready;
    logic tx_empty;
    logic tx_valid;
    logic tx_take;
    logic wr_go;
    logic wr_shadow;
    logic rd_go;
    logic rd_shadow;

    // An address hits the shadow block if it falls in any of the aliased words.
    function automatic logic shadow_hit(input logic [31:0] a);
        logic [31:0] off;
        off = a - SHADOW_BASE;
        return off < SHADOW_SPAN;
    endfunction : shadow_hit

    ////////////////////////////////////////////////////////////////////////////
    // Receive and transmit FIFOs; both are emptied when the FIFO mode changes.
    usdp_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH)
    ) u_rx_fifo (
        .clk(MCLK),
        .rst(RESET),
        .flush(flush),
        .push_valid(rx_push),
        .push_ready(rxf_ready),
        .push_data(rx_in.data),
        .pop_valid(rxf_valid),
        .pop_ready(rx_pop),
        .pop_data(rxf_data),
        .full(rxf_full)
    );

    usdp_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH)
    ) u_tx_fifo (
        .clk(MCLK),
        .rst(RESET),
        .flush(flush),
        .push_valid(tx_push),
        .push_ready(),
        .push_data(q.wdata),
        .pop_valid(txf_valid),
        .pop_ready(tx_pop),
        .pop_data(txf_data),
        .full()
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshakes: one write and one read in flight at a time.
    assign AWREADY = !q.aw_have && !q.bvalid;
    assign WREADY = !q.w_have && !q.bvalid;
    assign ARREADY = !q.rvalid;
    assign BVALID = q.bvalid;
    assign BRESP = q.bresp;
    assign RVALID = q.rvalid;
    assign RRESP = q.rresp;
    assign RDATA = {24'h00_0000, q.rdata};

    // Flags seen by software, taken from the holding registers or the FIFOs.
    assign data_ready = q.fifo_en ? rxf_valid : q.rx_valid;
    assign tx_empty = q.fifo_en ? !txf_valid : q.tx_holding_empty;

    // Line-side transmit strobe, steered to the selected output.
    assign tx_valid = q.fifo_en ? txf_valid : !q.tx_holding_empty;
    assign tx_take = tx_valid && TX_READY;
    assign tx_pop = q.fifo_en && tx_take;
    assign TX_DATA = q.fifo_en ? txf_data : q.tx_hold;
    assign UART_TX_VALID = tx_valid && !q.ir_mode;
    assign IR_TX_VALID = tx_valid && q.ir_mode;

    // Input selected by the mode; the other deserialiser is ignored.
    assign rx_in = q.ir_mode ? IR_RX : UART_RX;

    // Request decode.
    assign wr_go = q.aw_have && q.w_have && !q.bvalid;
    assign wr_shadow = wr_go && shadow_hit(q.awaddr) && q.wbyte;
    assign rd_go = ARVALID && ARREADY;
    assign rd_shadow = rd_go && shadow_hit(ARADDR);
    assign flush = (d.fifo_en != q.fifo_en);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: bus slave, holding registers, status flags.
    // Order matters: reads clear first, then line events set, so a set wins.
    always_comb begin
        d = q;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        tx_push = 1'b0;

        // Capture the write address and data in either order.
        if (AWVALID && AWREADY) begin
            d.aw_have = 1'b1;
            d.awaddr = AWADDR;
        end
        if (WVALID && WREADY) begin
            d.w_have = 1'b1;
            d.wdata = WDATA[7:0];
            d.wbyte = WSTRB[0];
        end

        // The serialiser taking the pending character empties the holding register.
        if (!q.fifo_en && tx_take) begin
            d.tx_holding_empty = 1'b1;
        end

        // Execute a write once both halves are held.
        if (wr_go) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            if (shadow_hit(q.awaddr)) begin
                if (q.wbyte && q.fifo_en) begin
                    tx_push = 1'b1;
                end else if (q.wbyte) begin
                    d.tx_hold = q.wdata;
                    d.tx_holding_empty = 1'b0;
                end
            end else if (q.awaddr == FIFO_CONTROL_ADDR) begin
                if (q.wbyte) begin
                    d.fifo_en = q.wdata[FIFO_ENABLE_BIT];
                end
            end else if (q.awaddr == MODE_CONTROL_ADDR) begin
                if (q.wbyte) begin
                    d.ir_mode = q.wdata[IR_MODE_BIT];
                end
            end else begin
                d.bresp = RESP_SLVERR;
            end
        end
        if (q.bvalid && BREADY) begin
            d.bvalid = 1'b0;
        end

        // Execute a read in the cycle its address is taken.
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = CHAR_RESET;
            if (shadow_hit(ARADDR)) begin
                d.rdata = q.fifo_en ? rxf_data : q.rx_hold;
                // Only a read that sees valid data consumes it.
                if (data_ready && q.fifo_en) begin
                    rx_pop = 1'b1;
                end else if (data_ready) begin
                    d.rx_valid = 1'b0;
                end
            end else if (ARADDR == FIFO_CONTROL_ADDR) begin
                d.rdata[FIFO_ENABLE_BIT] = q.fifo_en;
            end else if (ARADDR == MODE_CONTROL_ADDR) begin
                d.rdata[IR_MODE_BIT] = q.ir_mode;
            end else if (ARADDR == LINE_STATUS_ADDR) begin
                d.rdata[LS_DATA_READY_BIT] = data_ready;
                d.rdata[LS_OVERRUN_BIT] = q.overrun;
                d.rdata[LS_TX_EMPTY_BIT] = tx_empty;
                d.overrun = 1'b0;
            end else begin
                d.rresp = RESP_SLVERR;
            end
        end
        if (q.rvalid && RREADY) begin
            d.rvalid = 1'b0;
        end

        // Arrival of a character from the selected input.
        if (rx_in.valid && q.fifo_en) begin
            rx_push = 1'b1;
            if (!rxf_ready) begin
                d.overrun = 1'b1;
            end
        end else if (rx_in.valid) begin
            // A read in this same cycle has already cleared the flag.
            if (d.rx_valid) begin
                d.overrun = 1'b1;
            end
            d.rx_hold = rx_in.data;
            d.rx_valid = 1'b1;
        end
    end

    // State register; the holding register starts empty.
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            q <= '0;
            q.tx_holding_empty <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the data path.
    chk_upper_bits_zero: assert property (
        @(posedge MCLK) disable iff (RESET)
        RVALID |-> (RDATA[31:8] == 24'h00_0000))
        else $error("Upper read data bits not zero.");

    chk_alias_read_any: assert property (
        @(posedge MCLK) disable iff (RESET)
        (rd_shadow && !q.fifo_en) |=> (RVALID && RDATA[7:0] == $past(q.rx_hold)))
        else $error("Aliased read missed the receive buffer.");

    chk_fifo_head_read: assert property (
        @(posedge MCLK) disable iff (RESET)
        (rd_shadow && q.fifo_en) |=> (RDATA[7:0] == $past(rxf_data) && RVALID))
        else $error("Shadow read did not return the FIFO head.");

    chk_ready_gates_pop: assert property (
        @(posedge MCLK) disable iff (RESET)
        (rd_shadow && !data_ready && !rx_in.valid && !flush) |=> $stable(data_ready))
        else $error("Read without data ready changed the receive state.");

    chk_ir_input_used: assert property (
        @(posedge MCLK) disable iff (RESET)
        (!q.fifo_en && q.ir_mode && IR_RX.valid) |=> (q.rx_hold == $past(IR_RX.data)))
        else $error("Infrared character not captured.");

    chk_rx_overrun: assert property (
        @(posedge MCLK) disable iff (RESET)
        (!q.fifo_en && rx_in.valid && q.rx_valid && !rd_shadow)
        |=> (q.overrun && q.rx_hold == $past(rx_in.data)))
        else $error("Overwrite of unread character not flagged.");

    chk_rx_fifo_full: assert property (
        @(posedge MCLK) disable iff (RESET)
        (q.fifo_en && rx_in.valid && rxf_full && !rx_pop && !flush) |=> q.overrun)
        else $error("Drop at full receive FIFO not flagged.");

    chk_holding_clear: assert property (
        @(posedge MCLK) disable iff (RESET)
        (!q.fifo_en && !flush && wr_shadow && q.tx_holding_empty)
        |=> (!tx_empty && !q.tx_holding_empty))
        else $error("Holding-empty flag not cleared by a write.");

    // With FIFOs on, a shadow write always leaves something to send, even when dropped.
    chk_fifo_empty_clear: assert property (
        @(posedge MCLK) disable iff (RESET)
        (q.fifo_en && !flush && wr_shadow) |=> !tx_empty)
        else $error("Transmit FIFO stayed empty after a write.");

    // An arrival must be visible to software in the next cycle, whatever the mode.
    chk_ready_flag_set: assert property (
        @(posedge MCLK) disable iff (RESET)
        (rx_in.valid && !flush) |=> data_ready)
        else $error("Arrived character did not raise data ready.");

    chk_tx_replace: assert property (
        @(posedge MCLK) disable iff (RESET)
        (!q.fifo_en && wr_shadow) |=> (TX_DATA == $past(q.wdata)))
        else $error("Pending transmit character not replaced.");

    chk_tx_mode_steer: assert property (
        @(posedge MCLK) disable iff (RESET)
        (UART_TX_VALID || IR_TX_VALID) |-> (IR_TX_VALID == q.ir_mode && !UART_TX_VALID == q.ir_mode))
        else $error("Transmit strobe on the wrong output.");

endmodule : usdp_top

// ### rtl/usdp_pkg.sv
// Package with the address map, field positions and carriers of the shadow data port.
package usdp_pkg;

    // Sixteen aliased words end at the last shadow location.
    localparam logic [31:0] SHADOW_14_ADDR = 32'h5000_1168;
    localparam logic [31:0] SHADOW_15_ADDR = 32'h5000_116C;
    localparam logic [31:0] SHADOW_SPAN = 32'h0000_0040;
    localparam logic [31:0] SHADOW_BASE = SHADOW_15_ADDR - 32'h0000_003C;

    // Control and status words placed just above the shadow block.
    localparam logic [31:0] FIFO_CONTROL_ADDR = 32'h5000_1170;
    localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1174;
    localparam logic [31:0] MODE_CONTROL_ADDR = 32'h5000_1178;

    // Field positions.
    localparam int FIFO_ENABLE_BIT = 0;
    localparam int IR_MODE_BIT = 0;
    localparam int LS_DATA_READY_BIT = 0;
    localparam int LS_OVERRUN_BIT = 1;
    localparam int LS_TX_EMPTY_BIT = 5;

    // Values after reset and FIFO size.
    localparam logic [7:0] CHAR_RESET = 8'h00;
    localparam int FIFO_DEPTH = 16;

    // AXI4-Lite response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One character with its strobe, as passed in from the line side.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } usdp_char_s;

endpackage : usdp_pkg

// ### rtl/usdp_fifo.sv
// Character FIFO used for the receive and transmit paths.
`timescale 1ns/1ps
module usdp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic push_valid,
    output logic push_ready,
    input wire logic [WIDTH-1:0] push_data,
    output logic pop_valid,
    input wire logic pop_ready,
    output logic [WIDTH-1:0] pop_data,
    output logic full
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [CW-1:0] count;
    } usdp_fifo_s;

    usdp_fifo_s q;
    usdp_fifo_s d;
    logic push;
    logic pop;

    // A full FIFO still takes a push in the cycle it is popped.
    assign pop_valid = (q.count != '0);
    assign full = (q.count == CW'(DEPTH));
    assign push_ready = !full || pop_ready;
    assign pop_data = q.mem[q.rd];

    // Pointer and count update; flush empties the FIFO and wins over both sides.
    always_comb begin
        d = q;
        pop = pop_ready && pop_valid;
        push = push_valid && push_ready;
        if (flush) begin
            d.rd = '0;
            d.wr = '0;
            d.count = '0;
        end else begin
            if (push) begin
                d.mem[q.wr] = push_data;
                d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
            end
            if (pop) begin
                d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
            end
            d.count = q.count + CW'(push) - CW'(pop);
        end
    end

    // State register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_fifo_accepts: assert property (@(posedge clk) disable iff (rst)
        (!flush && push_valid && q.count < CW'(DEPTH))
        |=> (q.count == $past(q.count) + CW'(1) - CW'($past(pop))))
        else $error("FIFO refused a push below its depth.");

    chk_full_drops: assert property (@(posedge clk) disable iff (rst)
        (!flush && full && push_valid && !pop_ready) |=> ($stable(q.mem) && full))
        else $error("Full FIFO changed on a push.");

endmodule : usdp_fifo

// ### testbench/usdp_line_model.sv
// Line-side partner: a deserialiser that pulses characters and a serialiser that takes them.
`timescale 1ns/1ps
module usdp_line_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic [7:0] tx_data,
    input wire logic uart_tx_valid,
    input wire logic ir_tx_valid,
    output usdp_pkg::usdp_char_s uart_rx,
    output usdp_pkg::usdp_char_s ir_rx,
    output logic tx_ready
);
    import usdp_pkg::*;
    // Each taken character is kept with a flag that says it left on the infrared side.
    logic [8:0] tx_q[$];

    initial begin
        uart_rx = 9'h05A;
        ir_rx = 9'h0A5;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pulses n characters back to back; idle data then shows the inverse of the last.
    task automatic send_burst(input logic ir, input logic [7:0] d0, input int n);
        for (int i = 0; i < n; i++) begin
            if (ir) ir_rx <= {1'b1, d0 + i[7:0]};
            else uart_rx <= {1'b1, d0 + i[7:0]};
            @(posedge clk);
        end
        if (ir) ir_rx <= {1'b0, ~ir_rx.data};
        else uart_rx <= {1'b0, ~uart_rx.data};
    endtask : send_burst

    // A slow far end is modelled by holding its ready low while stalled.
    always @(posedge clk or posedge rst) begin
        if (rst) tx_ready <= 1'b0;
        else tx_ready <= !stall;
    end

    // A character leaves only at an edge where it is offered and ready is high.
    always @(posedge clk) begin
        if (!rst && tx_ready && (uart_tx_valid || ir_tx_valid)) tx_q.push_back({ir_tx_valid, tx_data});
    end
endmodule : usdp_line_model

// ### testbench/tb_top.sv
// Self-checking bench for the shadow data port.
`timescale 1ns/1ps
module tb_top;
    import usdp_pkg::*;
    localparam int DEPTH = FIFO_DEPTH;
    localparam logic [31:0] LS = LINE_STATUS_ADDR;
    logic MCLK = 1'b0;
    logic RESET = 1'b1;
    logic [31:0] AWADDR = '0, WDATA = '0, ARADDR = '0, RDATA, rd;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic [3:0] WSTRB = '0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_READY, UART_TX_VALID, IR_TX_VALID;
    logic [1:0] BRESP, RRESP, rsp;
    logic [7:0] TX_DATA;
    usdp_char_s UART_RX, IR_RX;
    logic stall = 1'b1;
    int fails = 0;
    int cmp_count = 0;

    usdp_top #(.DEPTH(DEPTH)) dut (.MCLK(MCLK), .RESET(RESET), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .UART_RX(UART_RX), .IR_RX(IR_RX), .TX_READY(TX_READY),
        .TX_DATA(TX_DATA), .UART_TX_VALID(UART_TX_VALID), .IR_TX_VALID(IR_TX_VALID));
    usdp_line_model u_line (.clk(MCLK), .rst(RESET), .stall(stall), .tx_data(TX_DATA),
        .uart_tx_valid(UART_TX_VALID), .ir_tx_valid(IR_TX_VALID), .uart_rx(UART_RX),
        .ir_rx(IR_RX), .tx_ready(TX_READY));

    // Free-running system clock.
    always #4 MCLK = ~MCLK;

    ////////////////////////////////////////////////////////////////////////////////
    task summarize;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task timeout;
        fails++;
        $display("MISMATCH handshake expected answer seen none");
        summarize();
    endtask : timeout

    // Ready levels are taken at the falling edge, which holds the value of the next rising one.
    task axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                   output logic [1:0] r);
        int n;
        logic aw_ok, w_ok, b_ok;
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        n = 0;
        b_ok = 1'b0;
        while (!b_ok) begin
            n++;
            if (n > 100) timeout();
            @(negedge MCLK);
            aw_ok = AWVALID && AWREADY;
            w_ok = WVALID && WREADY;
            b_ok = BVALID;
            r = BRESP;
            @(posedge MCLK);
            if (aw_ok) AWVALID <= 1'b0;
            if (w_ok) WVALID <= 1'b0;
        end
        BREADY <= 1'b0;
        @(posedge MCLK);
    endtask : axi_write

    task axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ar_ok, r_ok;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        n = 0;
        r_ok = 1'b0;
        while (!r_ok) begin
            n++;
            if (n > 100) timeout();
            @(negedge MCLK);
            ar_ok = ARVALID && ARREADY;
            r_ok = RVALID;
            d = RDATA;
            r = RRESP;
            @(posedge MCLK);
            if (ar_ok) ARVALID <= 1'b0;
        end
        RREADY <= 1'b0;
        @(posedge MCLK);
    endtask : axi_read

    task rd_chk(input string name, input logic [31:0] a, input logic [31:0] m,
                input logic [31:0] exp);
        axi_read(a, rd, rsp);
        check(name, rd & m, exp);
    endtask : rd_chk

    task wr(input logic [31:0] a, input logic [31:0] d);
        axi_write(a, d, 4'hF, rsp);
    endtask : wr

    // Waits for n characters on the line, then a few cycles more to catch any extra one.
    task wait_tx(input int n);
        int k;
        for (k = 0; k < 200 && u_line.tx_q.size() < n; k++) @(posedge MCLK);
        if (k == 200) timeout();
        repeat (4) @(posedge MCLK);
        check("tx count", u_line.tx_q.size(), n);
    endtask : wait_tx

    ////////////////////////////////////////////////////////////////////////////////
    task sc_reset;
        check("tx valids", {UART_TX_VALID, IR_TX_VALID}, 32'h0);
        rd_chk("status reset", LS, 32'h23, 32'h20);
        rd_chk("shadow reset", SHADOW_14_ADDR, 32'hFFFF_FFFF, 32'h0);
        axi_read(32'h5000_2000, rd, rsp);
        check("unmapped rresp", rsp, RESP_SLVERR);
        axi_write(32'h5000_2000, 32'h1, 4'hF, rsp);
        check("unmapped bresp", rsp, RESP_SLVERR);
    endtask : sc_reset

    task sc_rx_nofifo;
        u_line.send_burst(1'b0, 8'h5A, 1);
        rd_chk("status ready", LS, 32'h23, 32'h21);
        u_line.send_burst(1'b0, 8'hA5, 1);
        rd_chk("status overrun", LS, 32'h23, 32'h23);
        rd_chk("alias 3", SHADOW_BASE + 32'hC, 32'hFFFF_FFFF, 32'hA5);
        rd_chk("status drained", LS, 32'h23, 32'h20);
    endtask : sc_rx_nofifo

    task sc_ir;
        wr(MODE_CONTROL_ADDR, 32'h1);
        rd_chk("mode read", MODE_CONTROL_ADDR, 32'hFFFF_FFFF, 32'h1);
        u_line.send_burst(1'b0, 8'h77, 1);
        rd_chk("ir ignores uart", LS, 32'h23, 32'h20);
        u_line.send_burst(1'b1, 8'hC3, 1);
        rd_chk("ir read", SHADOW_15_ADDR, 32'hFFFF_FFFF, 32'hC3);
        u_line.tx_q.delete();
        stall <= 1'b0;
        wr(SHADOW_14_ADDR, 32'h3C);
        wait_tx(1);
        check("ir tx", u_line.tx_q[0], 32'h13C);
        stall <= 1'b1;
        wr(MODE_CONTROL_ADDR, 32'h0);
    endtask : sc_ir

    task sc_tx_nofifo;
        u_line.tx_q.delete();
        axi_write(SHADOW_BASE, 32'h55, 4'h0, rsp);
        rd_chk("strobe off", LS, 32'h23, 32'h20);
        wr(SHADOW_BASE + 32'h4, 32'h111);
        check("shadow bresp", rsp, RESP_OKAY);
        rd_chk("empty cleared", LS, 32'h23, 32'h0);
        check("tx data", TX_DATA, 32'h11);
        wr(SHADOW_BASE + 32'h8, 32'h22);
        check("tx replaced", TX_DATA, 32'h22);
        stall <= 1'b0;
        wait_tx(1);
        check("uart tx", u_line.tx_q[0], 32'h022);
        rd_chk("empty set", LS, 32'h23, 32'h20);
        stall <= 1'b1;
    endtask : sc_tx_nofifo

    task sc_fifo_rx;
        wr(FIFO_CONTROL_ADDR, 32'h1);
        rd_chk("fifo ctl read", FIFO_CONTROL_ADDR, 32'hFFFF_FFFF, 32'h1);
        u_line.send_burst(1'b0, 8'h40, DEPTH + 1);
        rd_chk("fifo overrun", LS, 32'h23, 32'h23);
        for (int i = 0; i < DEPTH; i++) begin
            rd_chk("fifo head", SHADOW_BASE + 32'(4 * i), 32'hFFFF_FFFF, 32'h40 + 32'(i));
        end
        rd_chk("fifo drained", LS, 32'h23, 32'h20);
    endtask : sc_fifo_rx

    task sc_fifo_tx;
        u_line.tx_q.delete();
        for (int i = 0; i <= DEPTH; i++) wr(SHADOW_BASE + 32'(4 * (i % 16)), 32'h60 + 32'(i));
        rd_chk("fifo busy", LS, 32'h23, 32'h0);
        stall <= 1'b0;
        wait_tx(DEPTH);
        for (int i = 0; i < u_line.tx_q.size(); i++) begin
            check("fifo tx", u_line.tx_q[i], 32'h60 + 32'(i));
        end
        rd_chk("fifo empty", LS, 32'h23, 32'h20);
    endtask : sc_fifo_tx

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for five cycles, then each scenario in turn.
    initial begin
        repeat (5) @(posedge MCLK);
        RESET <= 1'b0;
        @(posedge MCLK);
        sc_reset();
        sc_rx_nofifo();
        sc_ir();
        sc_tx_nofifo();
        sc_fifo_rx();
        sc_fifo_tx();
        summarize();
    end
endmodule : tb_top
